/* rtl/pfcs_bus_cycle.sv */
`timescale 1ns/1ps
`include "pfcs_params.svh"
// One strobed pin cycle: write (strobe pulse) or read (output gate low)
module pfcs_bus_cycle
    import pfcs_pkg::*;
#(
    parameter int SETUP_CYC = `PFCS_SETUP_CYC,
    parameter int LOW_CYC   = `PFCS_WE_LOW_CYC
) (
    input  wire logic       ref_clk,
    input  wire logic       srst,
    input  wire logic       start,
    input  wire logic       is_write,
    output logic            chip_sel_n,
    output logic            out_gate_n,
    output logic            wr_strobe_n,
    output logic            drive_en,
    output logic            sample,
    output logic            done
);
    import pfcs_pkg::*;

    localparam int CW = 8;

    pfcs_bus_t      st_q;
    pfcs_bus_t      st_d;
    logic [CW-1:0]  cnt_q;
    logic [CW-1:0]  cnt_d;
    logic           wr_q;
    logic           wr_d;
    logic           busy_q;
    logic           busy_d;
    logic           cs_q, cs_d, oe_q, oe_d, we_q, we_d, den_q, den_d, smp_q, smp_d, dn_q, dn_d;

    initial begin
        if (SETUP_CYC < 1 || LOW_CYC < 1 || SETUP_CYC > 255 || LOW_CYC > 255)
            $error("pfcs_bus_cycle: cycle counts out of range");
    end

    always_comb begin
        st_d   = st_q;
        cnt_d  = cnt_q;
        wr_d   = wr_q;
        busy_d = busy_q;
        cs_d   = cs_q;
        oe_d   = oe_q;
        we_d   = we_q;
        den_d  = den_q;
        smp_d  = 1'b0;
        dn_d   = 1'b0;
        if (!busy_q) begin
            if (start) begin
                busy_d = 1'b1;
                wr_d   = is_write;
                st_d   = PFCS_BS_SETUP;
                cnt_d  = CW'(SETUP_CYC - 1);
                cs_d   = 1'b0;
                oe_d   = is_write;     // Output gate held high during writes
                den_d  = is_write;
            end
        end else begin
            case (st_q)
                PFCS_BS_SETUP: begin
                    if (cnt_q == '0) begin
                        st_d  = PFCS_BS_LOW;
                        cnt_d = CW'(LOW_CYC - 1);
                        we_d  = !wr_q;
                        oe_d  = wr_q;
                    end else begin
                        cnt_d = cnt_q - 1'b1;
                    end
                end
                PFCS_BS_LOW: begin
                    if (cnt_q == '0) begin
                        st_d  = PFCS_BS_HOLD;
                        cnt_d = CW'(SETUP_CYC - 1);
                        we_d  = 1'b1;
                        smp_d = !wr_q;
                        oe_d  = 1'b1;
                    end else begin
                        cnt_d = cnt_q - 1'b1;
                    end
                end
                PFCS_BS_HOLD: begin
                    if (cnt_q == '0) begin
                        cs_d   = 1'b1;
                        den_d  = 1'b0;
                        busy_d = 1'b0;
                        dn_d   = 1'b1;
                        st_d   = PFCS_BS_SETUP;
                    end else begin
                        cnt_d = cnt_q - 1'b1;
                    end
                end
                default: st_d = PFCS_BS_SETUP;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            st_q   <= PFCS_BS_SETUP;
            cnt_q  <= '0;
            wr_q   <= 1'b0;
            busy_q <= 1'b0;
            cs_q   <= 1'b1;
            oe_q   <= 1'b1;
            we_q   <= 1'b1;
            den_q  <= 1'b0;
            smp_q  <= 1'b0;
            dn_q   <= 1'b0;
        end else begin
            st_q   <= st_d;
            cnt_q  <= cnt_d;
            wr_q   <= wr_d;
            busy_q <= busy_d;
            cs_q   <= cs_d;
            oe_q   <= oe_d;
            we_q   <= we_d;
            den_q  <= den_d;
            smp_q  <= smp_d;
            dn_q   <= dn_d;
        end
    end

    assign chip_sel_n  = cs_q;
    assign out_gate_n  = oe_q;
    assign wr_strobe_n = we_q;
    assign drive_en    = den_q;
    assign sample      = smp_q;
    assign done        = dn_q;
endmodule

/* rtl/pfcs_ctrl.sv */
// Implementation choices: the APB register port and the register offsets.
`timescale 1ns/1ps
`include "pfcs_params.svh"
//////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - Chip erase: AA/5555, 55/2AAA, 80/5555, AA/5555, 55/2AAA, 10/5555.
// - Byte program: AA/5555, 55/2AAA, A0/5555, then address and data.
// - Lockout enable: erase sequence ending with 40 to 5555.
// - Identification entry: AA/5555, 55/2AAA, 90/5555.
// - Identification exit: three writes ending F0/5555, or F0 anywhere.
//////////////////////////////////////////////////////////////////////////////
module pfcs_ctrl
    import pfcs_pkg::*;
#(
    parameter int ADDR_W    = 18,
    parameter int ERASE_CYC = `PFCS_ERASE_CYC,
    parameter int PROG_CYC  = `PFCS_PROG_CYC
) (
    input  wire logic              ref_clk,
    input  wire logic              srst,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [11:0]       paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    output logic                   irq,
    output logic      [ADDR_W-1:0] flash_addr,
    output logic                   flash_cs_n,
    output logic                   flash_oe_n,
    output logic                   flash_we_n,
    output logic      [7:0]        flash_dq_out,
    output logic                   flash_dq_oe,
    input  wire logic [7:0]        flash_dq_in
);
    import pfcs_pkg::*;

    localparam int TW = 32;

    initial begin
        if (ADDR_W != 18) $error("pfcs_ctrl: ADDR_W must be 18");
        if (ERASE_CYC < 2 || PROG_CYC < 2) $error("pfcs_ctrl: timeouts too small");
    end

    //////////////////////////////////////////////////////////////////////////
    // Pin cycle engine and input synchroniser
    logic       cyc_start, cyc_write, cyc_sample, cyc_done;
    logic [7:0] dq_sync;

    pfcs_sync #(.WIDTH(8)) u_sync (
        .ref_clk  (ref_clk),
        .srst     (srst),
        .async_in (flash_dq_in),
        .sync_out (dq_sync)
    );

    pfcs_bus_cycle u_cycle (
        .ref_clk     (ref_clk),
        .srst        (srst),
        .start       (cyc_start),
        .is_write    (cyc_write),
        .chip_sel_n  (flash_cs_n),
        .out_gate_n  (flash_oe_n),
        .wr_strobe_n (flash_we_n),
        .drive_en    (flash_dq_oe),
        .sample      (cyc_sample),
        .done        (cyc_done)
    );

    // Sampled byte sits in the second synchroniser stage one cycle later
    logic       smp_dly_q, smp_dly_d;

    //////////////////////////////////////////////////////////////////////////
    // Registers
    pfcs_op_t           op_q, op_d;
    logic [ADDR_W-1:0]  tgt_q, tgt_d;
    logic [7:0]         wdat_q, wdat_d;
    logic [7:0]         rdat_q, rdat_d;
    logic [7:0]         prev_q, prev_d;
    logic               busy_q, busy_d;
    logic               lock_q, lock_d;
    logic               tout_q, tout_d;
    logic [1:0]         ist_q, ist_d;
    logic [1:0]         imsk_q, imsk_d;
    logic [31:0]        prdata_q, prdata_d;
    logic               pready_q, pready_d;
    logic               pslverr_q, pslverr_d;
    logic               irq_q, irq_d;
    logic [ADDR_W-1:0]  fa_q, fa_d;
    logic [7:0]         fd_q, fd_d;

    // Sequencer
    pfcs_phase_t        ph_q, ph_d;
    logic [2:0]         step_q, step_d;
    logic [2:0]         nsteps;
    logic               pend_q, pend_d;
    logic               first_q, first_d;
    logic [TW-1:0]      tmr_q, tmr_d;
    logic               ev_done, ev_tout;

    // Address/data for each step of the chosen command
    always_comb begin
        nsteps = 3'd1;
        fa_d   = `PFCS_UNLOCK_A1;
        fd_d   = `PFCS_UNLOCK_D1;
        case (op_q)
            PFCS_OP_PROGRAM: nsteps = 3'd4;
            PFCS_OP_ERASE:   nsteps = 3'd6;
            PFCS_OP_LOCK:    nsteps = 3'd6;
            PFCS_OP_QUERY:   nsteps = 3'd3;
            PFCS_OP_ID_EXIT: nsteps = 3'd1;
            default:         nsteps = 3'd0;
        endcase
        case (step_q)
            3'd0, 3'd3: begin
                fa_d = `PFCS_UNLOCK_A1;
                fd_d = `PFCS_UNLOCK_D1;
            end
            3'd1, 3'd4: begin
                fa_d = `PFCS_UNLOCK_A2;
                fd_d = `PFCS_UNLOCK_D2;
            end
            3'd2: begin
                fa_d = `PFCS_UNLOCK_A1;
                case (op_q)
                    PFCS_OP_PROGRAM: fd_d = `PFCS_CMD_PROG;
                    PFCS_OP_QUERY:   fd_d = `PFCS_CMD_ID_ENTRY;
                    default:         fd_d = `PFCS_CMD_ERASE_PRE;
                endcase
            end
            default: begin
                fa_d = `PFCS_UNLOCK_A1;
                fd_d = (op_q == PFCS_OP_LOCK) ? `PFCS_CMD_LOCK : `PFCS_CMD_ERASE;
            end
        endcase
        if (op_q == PFCS_OP_PROGRAM && step_q == 3'd3) begin
            fa_d = tgt_q;
            fd_d = wdat_q;
        end
        if (op_q == PFCS_OP_ID_EXIT) begin
            fa_d = tgt_q;
            fd_d = `PFCS_CMD_ID_EXIT;
        end
        if (ph_q == PFCS_PH_READ || ph_q == PFCS_PH_POLL) begin
            fa_d = (op_q == PFCS_OP_QUERY) ? `PFCS_LOCK_QUERY_A : tgt_q;
            fd_d = fd_q;
        end
        if (ph_q == PFCS_PH_IDLE || ph_q == PFCS_PH_DONE) begin
            fa_d = fa_q;
            fd_d = fd_q;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Sequencer and register file next state
    always_comb begin
        logic wr_acc, rd_acc;
        logic [11:0] a;
        wr_acc    = psel && penable && pwrite && pready_q;
        rd_acc    = psel && penable && !pwrite && pready_q == 1'b0;
        a         = paddr;
        op_d      = op_q;
        tgt_d     = tgt_q;
        wdat_d    = wdat_q;
        rdat_d    = rdat_q;
        prev_d    = prev_q;
        busy_d    = busy_q;
        lock_d    = lock_q;
        tout_d    = tout_q;
        ist_d     = ist_q;
        imsk_d    = imsk_q;
        ph_d      = ph_q;
        step_d    = step_q;
        pend_d    = 1'b0;
        first_d   = first_q;
        tmr_d     = tmr_q;
        cyc_start = 1'b0;
        cyc_write = 1'b1;
        ev_done   = 1'b0;
        ev_tout   = 1'b0;
        smp_dly_d = cyc_sample;
        pready_d  = psel && penable && !pready_q;
        pslverr_d = 1'b0;
        prdata_d  = prdata_q;

        case (ph_q)
            PFCS_PH_IDLE: ;
            PFCS_PH_WRITE: begin
                if (cyc_done) begin
                    step_d = step_q + 3'd1;
                    if (step_q + 3'd1 >= nsteps) begin
                        case (op_q)
                            PFCS_OP_QUERY: begin
                                ph_d   = PFCS_PH_READ;
                                pend_d = 1'b1;
                            end
                            PFCS_OP_ID_EXIT: ph_d = PFCS_PH_DONE;
                            default: begin
                                ph_d    = PFCS_PH_POLL;
                                pend_d  = 1'b1;
                                first_d = 1'b1;
                                tmr_d   = (op_q == PFCS_OP_PROGRAM) ? TW'(PROG_CYC) : TW'(ERASE_CYC);
                            end
                        endcase
                    end else begin
                        pend_d = 1'b1;
                    end
                end
            end
            PFCS_PH_READ, PFCS_PH_POLL: begin
                if (ph_q == PFCS_PH_POLL && tmr_q != '0) tmr_d = tmr_q - 1'b1;
                if (smp_dly_q) begin
                    rdat_d = dq_sync;
                    prev_d = dq_sync;
                    first_d = 1'b0;
                    if (ph_q == PFCS_PH_READ) begin
                        if (op_q == PFCS_OP_QUERY) lock_d = dq_sync[0];
                        ph_d = PFCS_PH_DONE;
                    end else if (!first_q && dq_sync[6] == prev_q[6]) begin
                        ph_d = PFCS_PH_DONE;
                        if (op_q == PFCS_OP_LOCK) lock_d = 1'b1;
                    end else if (tmr_q == '0) begin
                        tout_d  = 1'b1;
                        ev_tout = 1'b1;
                        ph_d    = PFCS_PH_DONE;
                    end else begin
                        pend_d = 1'b1;
                    end
                end
            end
            PFCS_PH_DONE: begin
                ph_d    = PFCS_PH_IDLE;
                busy_d  = 1'b0;
                ev_done = 1'b1;
                step_d  = 3'd0;
            end
            default: ph_d = PFCS_PH_IDLE;
        endcase

        // Launch next pin cycle one clock after a write cycle's done pulse, or in the same clock as a read cycle's done pulse
        if (pend_q) begin
            cyc_start = 1'b1;
            cyc_write = (ph_q == PFCS_PH_WRITE);
        end

        if (wr_acc) begin
            case (a)
                `PFCS_REG_CTRL: begin
                    if (!busy_q && pwdata[`PFCS_CTRL_GO_BIT]) begin
                        op_d   = pfcs_op_t'(pwdata[`PFCS_CTRL_CMD_LSB +: `PFCS_CTRL_CMD_W]);
                        step_d = 3'd0;
                        tout_d = 1'b0;
                        ph_d   = (pfcs_op_t'(pwdata[`PFCS_CTRL_CMD_LSB +: `PFCS_CTRL_CMD_W]) == PFCS_OP_READ)
                                 ? PFCS_PH_READ : PFCS_PH_WRITE;
                        pend_d = 1'b1;
                        busy_d = 1'b1;
                    end
                end
                `PFCS_REG_ADDR:     if (!busy_q) tgt_d = pwdata[ADDR_W-1:0];
                `PFCS_REG_WDATA:    if (!busy_q) wdat_d = pwdata[7:0];
                `PFCS_REG_IRQ_STAT: ist_d = ist_q & ~pwdata[1:0];
                `PFCS_REG_IRQ_MASK: imsk_d = pwdata[1:0];
                default: ;
            endcase
        end
        if (ev_done) ist_d[`PFCS_IRQ_DONE_BIT] = 1'b1;
        if (ev_tout) ist_d[`PFCS_IRQ_TOUT_BIT] = 1'b1;

        if (rd_acc) begin
            case (a)
                `PFCS_REG_CTRL:     prdata_d = {25'h0, op_q, 4'h0};
                `PFCS_REG_ADDR:     prdata_d = {14'h0, tgt_q};
                `PFCS_REG_WDATA:    prdata_d = {24'h0, wdat_q};
                `PFCS_REG_RDATA:    prdata_d = {24'h0, rdat_q};
                `PFCS_REG_STATUS:   prdata_d = {29'h0, tout_q, lock_q, busy_q};
                `PFCS_REG_IRQ_STAT: prdata_d = {30'h0, ist_q};
                `PFCS_REG_IRQ_MASK: prdata_d = {30'h0, imsk_q};
                default: begin
                    prdata_d  = 32'h0;
                    pslverr_d = 1'b1;
                end
            endcase
        end else if (psel && penable && pwrite && !pready_q && a > `PFCS_REG_IRQ_MASK) begin
            pslverr_d = 1'b1;
        end
        irq_d = |(ist_d & imsk_d);
    end

    //////////////////////////////////////////////////////////////////////////
    // State registers
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            op_q <= PFCS_OP_READ;
            ph_q <= PFCS_PH_IDLE;
            {busy_q, lock_q, tout_q, ist_q, imsk_q, pend_q, first_q, step_q, tmr_q} <= '0;
            {pready_q, pslverr_q, irq_q, smp_dly_q, prdata_q} <= '0;
            {tgt_q, wdat_q, rdat_q, prev_q, fa_q, fd_q} <= '0;
        end else begin
            op_q <= op_d;
            ph_q <= ph_d;
            {busy_q, lock_q, tout_q, ist_q, imsk_q, pend_q, first_q, step_q, tmr_q} <=
                {busy_d, lock_d, tout_d, ist_d, imsk_d, pend_d, first_d, step_d, tmr_d};
            {pready_q, pslverr_q, irq_q, smp_dly_q, prdata_q} <= {pready_d, pslverr_d, irq_d, smp_dly_d, prdata_d};
            {tgt_q, wdat_q, rdat_q, prev_q, fa_q, fd_q} <= {tgt_d, wdat_d, rdat_d, prev_d, fa_d, fd_d};
        end
    end

    assign prdata       = prdata_q;
    assign pready       = pready_q;
    assign pslverr      = pslverr_q;
    assign irq          = irq_q;
    assign flash_addr   = fa_q;
    assign flash_dq_out = fd_q;
endmodule

/* rtl/pfcs_params.svh */
`ifndef PFCS_PARAMS_SVH
`define PFCS_PARAMS_SVH

// Register offsets (byte addresses on APB)
`define PFCS_REG_CTRL      12'h000
`define PFCS_REG_ADDR      12'h004
`define PFCS_REG_WDATA     12'h008
`define PFCS_REG_RDATA     12'h00c
`define PFCS_REG_STATUS    12'h010
`define PFCS_REG_IRQ_STAT  12'h014
`define PFCS_REG_IRQ_MASK  12'h018

// Control fields
`define PFCS_CTRL_GO_BIT   0
`define PFCS_CTRL_CMD_LSB  4
`define PFCS_CTRL_CMD_W    3

// Status fields
`define PFCS_ST_BUSY_BIT   0
`define PFCS_ST_LOCK_BIT   1
`define PFCS_ST_TOUT_BIT   2

// Interrupt status fields
`define PFCS_IRQ_DONE_BIT  0
`define PFCS_IRQ_TOUT_BIT  1
`define PFCS_IRQ_W         2

// Command sequence addresses and data
`define PFCS_UNLOCK_A1     18'h05555
`define PFCS_UNLOCK_A2     18'h02aaa
`define PFCS_UNLOCK_D1     8'haa
`define PFCS_UNLOCK_D2     8'h55
`define PFCS_CMD_ERASE_PRE 8'h80
`define PFCS_CMD_ERASE     8'h10
`define PFCS_CMD_PROG      8'ha0
`define PFCS_CMD_LOCK      8'h40
`define PFCS_CMD_ID_ENTRY  8'h90
`define PFCS_CMD_ID_EXIT   8'hf0
`define PFCS_LOCK_QUERY_A  18'h00002
`define PFCS_BOOT_LAST     18'h01fff

// Timing: 40 MHz clock, 25 ns period
`define PFCS_CLK_PERIOD_NS 25
`define PFCS_WE_LOW_NS     100
`define PFCS_WE_LOW_CYC    ((`PFCS_WE_LOW_NS + `PFCS_CLK_PERIOD_NS - 1) / `PFCS_CLK_PERIOD_NS)
`define PFCS_SETUP_NS      50
`define PFCS_SETUP_CYC     ((`PFCS_SETUP_NS + `PFCS_CLK_PERIOD_NS - 1) / `PFCS_CLK_PERIOD_NS)
`define PFCS_READ_NS       100
`define PFCS_READ_CYC      ((`PFCS_READ_NS + `PFCS_CLK_PERIOD_NS - 1) / `PFCS_CLK_PERIOD_NS)
// chip_erase_time 10 s; byte_program_time 50 us; polling bound set to exactly these times
`define PFCS_ERASE_TIME_MS 10000
`define PFCS_ERASE_CYC     (`PFCS_ERASE_TIME_MS * 40000)
`define PFCS_PROG_TIME_US  50
`define PFCS_PROG_CYC      (`PFCS_PROG_TIME_US * 40)

`endif

/* rtl/pfcs_pkg.sv */
package pfcs_pkg;
    typedef enum logic [2:0] {
        PFCS_OP_READ    = 3'h0,
        PFCS_OP_PROGRAM = 3'h1,
        PFCS_OP_ERASE   = 3'h2,
        PFCS_OP_LOCK    = 3'h3,
        PFCS_OP_QUERY   = 3'h4,
        PFCS_OP_ID_EXIT = 3'h5
    } pfcs_op_t;

    typedef enum logic [2:0] {
        PFCS_PH_IDLE  = 3'b000,
        PFCS_PH_WRITE = 3'b001,
        PFCS_PH_READ  = 3'b110,
        PFCS_PH_POLL  = 3'b011,
        PFCS_PH_DONE  = 3'b010
    } pfcs_phase_t;

    typedef enum logic [1:0] {
        PFCS_BS_SETUP = 2'b00,
        PFCS_BS_LOW   = 2'b01,
        PFCS_BS_HOLD  = 2'b11
    } pfcs_bus_t;
endpackage

/* rtl/pfcs_sync.sv */
`timescale 1ns/1ps
module pfcs_sync #(
    parameter int WIDTH = 8
) (
    input  wire logic             ref_clk,
    input  wire logic             srst,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] meta_d;
    logic [WIDTH-1:0] sync_q;
    logic [WIDTH-1:0] sync_d;

    initial begin
        if (WIDTH < 1) $error("pfcs_sync: WIDTH must be positive");
    end

    always_comb begin
        meta_d = async_in;
        sync_d = meta_q;
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign sync_out = sync_q;
endmodule

/* tb/pfcs_ctrl_assertions.sv */
`timescale 1ns/1ps
module pfcs_ctrl_assertions #(
    parameter int ADDR_W = 18
) (
    input wire logic              ref_clk,
    input wire logic              srst,
    input wire logic              irq,
    input wire logic [ADDR_W-1:0] flash_addr,
    input wire logic              flash_cs_n,
    input wire logic              flash_oe_n,
    input wire logic              flash_we_n,
    input wire logic [7:0]        flash_dq_out,
    input wire logic              flash_dq_oe
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (srst);
    wr_inhibit_a: assert property (!flash_we_n |-> flash_oe_n && !flash_cs_n)
        else $error("write strobe outside a clean write");
    no_contend_a: assert property (flash_dq_oe |-> flash_oe_n)
        else $error("data driven while gate low");
    read_mode_a: assert property (!flash_oe_n |-> flash_we_n && !flash_cs_n)
        else $error("gate low outside a read");
    we_width_a: assert property ($fell(flash_we_n) |-> !flash_we_n [*4])
        else $error("write strobe pulse too short");
    data_drive_a: assert property (!flash_we_n |-> flash_dq_oe)
        else $error("write strobe without data");
    addr_hold_a: assert property (!flash_we_n && !$past(flash_we_n) |-> $stable(flash_addr) && $stable(flash_dq_out))
        else $error("address or data moved in strobe");
    data_rise_a: assert property ($rose(flash_we_n) |-> flash_dq_oe && $stable(flash_dq_out))
        else $error("data lost at strobe rise");
    cs_frame_a: assert property ($rose(flash_cs_n) |-> flash_we_n && flash_oe_n)
        else $error("deselect before strobes released");
    cover property ($fell(flash_we_n));
    cover property ($fell(flash_oe_n));
    cover property ($rose(irq));
endmodule

/* tb/pfcs_flash_model.sv */
`timescale 1ns/1ps
module pfcs_flash_model #(
    parameter int         PROG_NS  = 2000,
    parameter int         ERASE_NS = 20000,
    parameter logic [7:0] MFR_ID   = 8'h3c,  // Arbitrary value
    parameter logic [7:0] DEV_ID   = 8'hc3   // Arbitrary value
) (
    input wire logic [17:0] addr,
    input wire logic        cs_n,
    input wire logic        oe_n,
    input wire logic        we_n,
    input wire logic [7:0]  dq_in,
    output logic     [7:0]  dq_out,
    output logic            dq_oe
);
    logic [7:0]  mem [int];
    logic [7:0]  last_d = 8'hff;
    logic [17:0] a_q;
    bit          busy, lock, idm, tog;
    int          st;
    realtime     t0;
    wire act = !cs_n && !we_n && oe_n;
    function automatic logic [7:0] rd(int a);
        return mem.exists(a) ? mem[a] : 8'hff;
    endfunction
    always @(posedge act) begin
        a_q = addr;
        t0 = $realtime;
    end
    always @(negedge act) if (!busy && $realtime - t0 >= 15) begin
        if (st == 6) begin
            busy = 1;
            last_d = dq_in;
            st = 0;
            fork begin
                #PROG_NS;
                if (!(lock && a_q <= 18'h01fff)) mem[a_q] = rd(a_q) & last_d;
                busy = 0;
            end join_none
        end else if (dq_in == 8'hf0) begin
            idm = 0;
            st = 0;
        end else if (st == 0 || st == 3) st = (a_q == 18'h05555 && dq_in == 8'haa) ? st + 1 : 0;
        else if (st == 1 || st == 4) st = (a_q == 18'h02aaa && dq_in == 8'h55) ? st + 1 : 0;
        else if (a_q != 18'h05555) st = 0;
        else if (st == 2) begin
            if (dq_in == 8'h90) idm = 1;
            st = dq_in == 8'h80 ? 3 : dq_in == 8'ha0 ? 6 : 0;
        end else begin
            if (dq_in == 8'h10) begin
                busy = 1;
                last_d = 8'hff;
                fork begin
                    #ERASE_NS;
                    foreach (mem[k]) if (!(lock && k <= 'h1fff)) mem[k] = 8'hff;
                    busy = 0;
                end join_none
            end else if (dq_in == 8'h40) lock = 1;
            st = 0;
        end
    end
    always @(posedge (!cs_n && !oe_n)) if (busy) tog = !tog;
    assign dq_oe = !cs_n && !oe_n && we_n;
    always @(addr or busy or idm or lock or tog or oe_n)
        dq_out = busy ? {~last_d[7], tog, last_d[5:0]} :
                 idm ? (addr == 0 ? MFR_ID : addr == 1 ? DEV_ID : addr == 2 ? {7'h0, lock} : 8'hff) : rd(addr);
endmodule

/* tb/testbench.sv */
`timescale 1ns/1ps
`include "pfcs_params.svh"
module testbench;
    import pfcs_pkg::*;
    logic        ref_clk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0, locked = 0;
    logic [11:0] paddr  = '0;
    logic [31:0] pwdata = '0;
    logic [31:0] prdata, rd;
    logic        pready, pslverr, irq, cs_n, oe_n, we_n, dq_oe, m_oe, err;
    logic [17:0] fa;
    logic [7:0]  dq_o, m_dq;
    logic [7:0]  shadow [int];
    int          fails = 0, n_tests = 0, seed = 32'h98cd;
    wire  [7:0]  dq = dq_oe ? dq_o : m_oe ? m_dq : 8'h5a ^ {8{ref_clk}};
    initial forever #12.5 ref_clk = ~ref_clk;
    pfcs_ctrl #(.ADDR_W(18), .ERASE_CYC(4000), .PROG_CYC(400)) dut_u (.ref_clk(ref_clk), .srst(srst),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .irq(irq), .flash_addr(fa), .flash_cs_n(cs_n), .flash_oe_n(oe_n),
        .flash_we_n(we_n), .flash_dq_out(dq_o), .flash_dq_oe(dq_oe), .flash_dq_in(dq));
    pfcs_flash_model flash_u (.addr(fa), .cs_n(cs_n), .oe_n(oe_n), .we_n(we_n), .dq_in(dq), .dq_out(m_dq),
        .dq_oe(m_oe));
    task automatic summarize;
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string m);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int i = 0;
        @(posedge ref_clk);
        psel <= 1; pwrite <= wr; paddr <= a; pwdata <= d;
        @(posedge ref_clk);
        penable <= 1;
        do begin @(posedge ref_clk); i++; end while (pready !== 1'b1 && i < 200);
        if (i >= 200) begin fails++; $display("[ERR] %0t bus timeout", $time); summarize(); end
        rd = prdata;
        err = pslverr;
        psel <= 0; penable <= 0;
    endtask
    function automatic logic [7:0] exp_rd(int a);
        return shadow.exists(a) ? shadow[a] : 8'hff;
    endfunction
    task automatic op(input pfcs_op_t c, input logic [17:0] a, input logic [7:0] d);
        int i = 0;
        apb(1, `PFCS_REG_ADDR, {14'h0, a});
        apb(1, `PFCS_REG_WDATA, {24'h0, d});
        apb(1, `PFCS_REG_CTRL, {25'h0, c, 4'h1});
        do begin apb(0, `PFCS_REG_STATUS, 0); i++; end while (rd[0] !== 1'b0 && i < 3000);
        if (i >= 3000) begin fails++; $display("[ERR] %0t busy timeout", $time); summarize(); end
    endtask
    task automatic rdchk(input logic [17:0] a);
        op(PFCS_OP_READ, a, 8'h00);
        apb(0, `PFCS_REG_RDATA, 0);
        check(rd[7:0], exp_rd(a), "read");
    endtask
    task automatic prog(input logic [17:0] a, input logic [7:0] d);
        op(PFCS_OP_PROGRAM, a, d);
        if (a > 18'h01fff || !locked) shadow[a] = exp_rd(a) & d;
        rdchk(a);
    endtask
    initial begin
        logic [17:0] a;
        repeat (12) @(posedge ref_clk);
        srst <= 0;
        apb(0, `PFCS_REG_IRQ_STAT, 0);
        check(rd, 0, "irq status reset");
        apb(0, 12'h01c, 0);
        check({31'h0, err}, 1, "unmapped read error");
        apb(1, `PFCS_REG_IRQ_MASK, 3);
        prog(18'h00100, 8'h00);
        check({31'h0, irq}, 1, "irq raised");
        apb(1, `PFCS_REG_IRQ_STAT, 3);
        apb(0, `PFCS_REG_IRQ_STAT, 0);
        check({rd[0], irq}, 0, "irq cleared");
        apb(1, `PFCS_REG_IRQ_MASK, 0);
        for (int k = 0; k < 4; k++) begin
            a = 18'h02000 | 18'($random(seed));
            repeat (2) prog(a, 8'($random(seed)));
        end
        apb(0, `PFCS_REG_IRQ_STAT, 0);
        check({rd[0], irq}, 2'b10, "irq masked");
        op(PFCS_OP_QUERY, 18'h00002, 8'h00);
        apb(0, `PFCS_REG_STATUS, 0);
        check(rd[1], 0, "lock clear");
        op(PFCS_OP_ID_EXIT, 18'h0, 8'h00);
        rdchk(18'h00100);
        op(PFCS_OP_LOCK, 18'h0, 8'h00);
        locked = 1;
        op(PFCS_OP_QUERY, 18'h00002, 8'h00);
        apb(0, `PFCS_REG_STATUS, 0);
        check(rd[1], 1, "lock set");
        op(PFCS_OP_ID_EXIT, 18'h0, 8'h00);
        prog(18'h01fff, 8'h00);
        op(PFCS_OP_ERASE, 18'h0, 8'h00);
        foreach (shadow[k]) if (k > 'h1fff) shadow[k] = 8'hff;
        rdchk(18'h00100);
        rdchk(a);
        apb(0, `PFCS_REG_STATUS, 0);
        check(rd[2], 0, "no timeout");
        summarize();
    end
endmodule
bind pfcs_ctrl pfcs_ctrl_assertions #(.ADDR_W(ADDR_W)) chk_u (.ref_clk(ref_clk), .srst(srst), .irq(irq),
    .flash_addr(flash_addr), .flash_cs_n(flash_cs_n), .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n),
    .flash_dq_out(flash_dq_out), .flash_dq_oe(flash_dq_oe));
